/* rtl/supervisor_pkg.sv */
// constants and types shared by the buck supply supervisor
package supervisor_pkg;

   // register byte offsets on the wishbone slave
   localparam logic [7:0] STATUS_OFFSET = 8'h00;
   localparam logic [7:0] LIMITS_OFFSET = 8'h04;
   localparam logic [7:0] PRESETS_OFFSET = 8'h08;
   localparam logic [7:0] RESTART_OFFSET = 8'h0C;

   // status word field positions
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_GOOD_BIT = 4;
   localparam int STAT_ALARM_BIT = 5;
   localparam int STAT_DRIVE_BIT = 6;
   localparam int STAT_BUDGET_LSB = 8;
   localparam int STAT_DUTY_LSB = 16;

   // limits word field positions, one byte each
   localparam int LOCKOUT_LSB = 0;
   localparam int TEMP_SET_LSB = 8;
   localparam int TEMP_CLEAR_LSB = 16;
   localparam int OVERCURRENT_LSB = 24;

   // widths
   localparam int MEAS_W = 8;
   localparam int BUDGET_W = 4;
   localparam int DELAY_W = 7;

   // values after reset
   localparam logic [31:0] LIMITS_RESET = 32'hE0A0_C040;
   localparam logic [31:0] PRESETS_RESET = 32'hC0A0_8060;
   localparam logic [BUDGET_W-1:0] RESTART_MAX_RESET = 4'h3;

   // start delay preload, in ticks
   localparam logic [DELAY_W-1:0] START_DELAY_TICKS = 7'h64;

   typedef enum logic [2:0] {
      off_state,
      delay_state,
      ramp_state,
      active_state,
      error_state,
      fault_state
   } state_t;

endpackage

/* rtl/smps_supervisor_fsm.sv */
// supervisory state machine for a buck supply, with a wishbone register slave
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - six states: off, start delay, ramping, active, active-with-error, latched fault.
// - off moves to delay when run is high and input exceeds lockout level.
// - off preloads delay counter to 100; delay counts down, ramps at zero.
// - ramping steps duty one count per tick, drives, goes active at target.
// - one ramp state serves both directions, soft start included.
// - active returns to ramping whenever duty differs from target.
// - run low or input below lockout forces off, overriding all else.
// - active enters error when temperature exceeds the set threshold.
// - error returns to active only below the lower clear threshold.
// - output under half target in active or error with zero budget latches fault.
// - short with budget above zero decrements budget and goes off.
// - budget reloads only in off with run low.
// - fault exits only to off; the host releases it by dropping run.
// - in active, alarm follows the over-current comparison.
// - good in active and error, alarm held in error, good low in fault.
// - a later-checked transition condition wins over earlier ones.
// - an illegal state encoding forces the off state.
// - reset puts the state register in off.
// - target comes from four presets picked by the two select lines.
module smps_supervisor_fsm (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic TICK_I,
   input wire logic RUN_I,
   input wire logic [1:0] PRESET_SEL_I,
   input wire logic [supervisor_pkg::MEAS_W-1:0] VIN_MEAS_I,
   input wire logic [supervisor_pkg::MEAS_W-1:0] VOUT_MEAS_I,
   input wire logic [supervisor_pkg::MEAS_W-1:0] CURRENT_MEAS_I,
   input wire logic [supervisor_pkg::MEAS_W-1:0] TEMP_MEAS_I,
   output logic OUTPUT_GOOD_FLAG_O,
   output logic ALARM_INDICATOR_O,
   output logic [supervisor_pkg::MEAS_W-1:0] REFERENCE_DUTY_O,
   output logic DRIVE_ENABLE_O
);
   import supervisor_pkg::*;

   typedef struct packed {
      logic run_meta;
      logic run_sync;
      logic [1:0] sel_meta;
      logic [1:0] sel_sync;
      logic ack;
      logic [31:0] rdata;
      logic [31:0] limits;
      logic [31:0] presets;
      logic [BUDGET_W-1:0] restart_budget_max;
      state_t state;
      logic [DELAY_W-1:0] start_delay_counter;
      logic [BUDGET_W-1:0] budget;
      logic [MEAS_W-1:0] reference_duty;
      logic output_good_flag;
      logic alarm_indicator;
      logic drive;
   } regs_t;

   regs_t r;
   regs_t next_r;

   logic [MEAS_W-1:0] target;
   logic [MEAS_W-1:0] input_lockout_level;
   logic [MEAS_W-1:0] temp_set_threshold;
   logic [MEAS_W-1:0] temp_clear_threshold;
   logic [MEAS_W-1:0] overcurrent_threshold;
   logic release_hit;
   logic start_ok;
   logic short_hit;

   ////////////////////////////////////////////////////////////////////////////
   // preset lookup; select lines index a byte of the preset word
   function automatic logic [MEAS_W-1:0] preset_pick(input logic [31:0] table_w, input logic [1:0] idx);
      logic [MEAS_W-1:0] v;
      v = '0;
      case (idx)
         2'h0: v = table_w[7:0];
         2'h1: v = table_w[15:8];
         2'h2: v = table_w[23:16];
         default: v = table_w[31:24];
      endcase
      return v;
   endfunction

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] lanes);
      logic [31:0] v;
      v = old_w;
      for (int i = 0; i < 4; i++) begin
         if (lanes[i]) begin
            v[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // decoded thresholds and comparisons seen by the machine
   assign target = preset_pick(r.presets, r.sel_sync);
   assign input_lockout_level = r.limits[LOCKOUT_LSB +: MEAS_W];
   assign temp_set_threshold = r.limits[TEMP_SET_LSB +: MEAS_W];
   assign temp_clear_threshold = r.limits[TEMP_CLEAR_LSB +: MEAS_W];
   assign overcurrent_threshold = r.limits[OVERCURRENT_LSB +: MEAS_W];
   assign release_hit = !r.run_sync || (VIN_MEAS_I < input_lockout_level);
   assign start_ok = r.run_sync && (VIN_MEAS_I > input_lockout_level);
   assign short_hit = VOUT_MEAS_I < (target >> 1);

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic: synchronisers, bus slave, supervisor machine
   always_comb begin
      logic [31:0] status_w;
      status_w = '0;
      next_r = r;

      // pin synchronisers
      next_r.run_meta = RUN_I;
      next_r.run_sync = r.run_meta;
      next_r.sel_meta = PRESET_SEL_I;
      next_r.sel_sync = r.sel_meta;

      // status word
      status_w[STAT_STATE_LSB +: 3] = r.state;
      status_w[STAT_GOOD_BIT] = r.output_good_flag;
      status_w[STAT_ALARM_BIT] = r.alarm_indicator;
      status_w[STAT_DRIVE_BIT] = r.drive;
      status_w[STAT_BUDGET_LSB +: BUDGET_W] = r.budget;
      status_w[STAT_DUTY_LSB +: MEAS_W] = r.reference_duty;

      // wishbone: one-cycle registered answer, ack dropped the cycle after
      next_r.ack = 1'b0;
      if (CYC_I && STB_I && !r.ack) begin
         next_r.ack = 1'b1;
         next_r.rdata = '0;
         case (ADR_I)
            STATUS_OFFSET: next_r.rdata = status_w;
            LIMITS_OFFSET: begin
               next_r.rdata = r.limits;
               if (WE_I) begin
                  next_r.limits = lane_merge(r.limits, DAT_I, SEL_I);
               end
            end
            PRESETS_OFFSET: begin
               next_r.rdata = r.presets;
               if (WE_I) begin
                  next_r.presets = lane_merge(r.presets, DAT_I, SEL_I);
               end
            end
            RESTART_OFFSET: begin
               next_r.rdata[BUDGET_W-1:0] = r.restart_budget_max;
               if (WE_I && SEL_I[0]) begin
                  next_r.restart_budget_max = DAT_I[BUDGET_W-1:0];
               end
            end
            default: next_r.rdata = '0;
         endcase
      end

      // supervisor evaluates only on a tick
      if (TICK_I) begin
         case (r.state)
            off_state: begin
               next_r.start_delay_counter = START_DELAY_TICKS;
               if (!r.run_sync) begin
                  next_r.budget = r.restart_budget_max;
               end
               if (start_ok) begin
                  next_r.state = delay_state;
               end
            end
            delay_state: begin
               next_r.start_delay_counter = r.start_delay_counter - 7'h01;
               if (next_r.start_delay_counter == '0) begin
                  next_r.state = ramp_state;
               end
            end
            ramp_state: begin
               // same state slews both ways
               if (r.reference_duty < target) begin
                  next_r.reference_duty = r.reference_duty + 8'h01;
               end else if (r.reference_duty > target) begin
                  next_r.reference_duty = r.reference_duty - 8'h01;
               end
               if (next_r.reference_duty == target) begin
                  next_r.state = active_state;
               end
            end
            active_state: begin
               if (r.reference_duty != target) begin
                  next_r.state = ramp_state;
               end
               if (TEMP_MEAS_I > temp_set_threshold) begin
                  next_r.state = error_state;
               end
               if (short_hit) begin
                  if (r.budget == '0) begin
                     next_r.state = fault_state;
                  end else begin
                     next_r.budget = r.budget - 4'h1;
                     next_r.state = off_state;
                  end
               end
            end
            error_state: begin
               if (TEMP_MEAS_I < temp_clear_threshold) begin
                  next_r.state = active_state;
               end
               if (short_hit) begin
                  if (r.budget == '0) begin
                     next_r.state = fault_state;
                  end else begin
                     next_r.budget = r.budget - 4'h1;
                     next_r.state = off_state;
                  end
               end
            end
            fault_state: begin
               next_r.state = fault_state;
            end
            default: begin
               next_r.state = off_state;
            end
         endcase

         // checked last so it overrides every other transition
         if (release_hit) begin
            next_r.state = off_state;
         end

         // every way into off rearms the full start delay, not only a tick spent in off
         if (next_r.state == off_state) begin
            next_r.start_delay_counter = START_DELAY_TICKS;
         end

         // outputs follow the state being entered
         case (next_r.state)
            off_state, delay_state, fault_state: begin
               next_r.reference_duty = '0;
               next_r.drive = 1'b0;
               next_r.output_good_flag = 1'b0;
               next_r.alarm_indicator = 1'b1;
            end
            ramp_state: begin
               next_r.drive = 1'b1;
               next_r.output_good_flag = 1'b0;
               next_r.alarm_indicator = 1'b0;
            end
            active_state: begin
               next_r.drive = 1'b1;
               next_r.output_good_flag = 1'b1;
               next_r.alarm_indicator = CURRENT_MEAS_I > overcurrent_threshold;
            end
            default: begin
               next_r.drive = 1'b1;
               next_r.output_good_flag = 1'b1;
               next_r.alarm_indicator = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         r.run_meta <= 1'b0;
         r.run_sync <= 1'b0;
         r.sel_meta <= 2'h0;
         r.sel_sync <= 2'h0;
         r.ack <= 1'b0;
         r.rdata <= 32'h0000_0000;
         r.limits <= LIMITS_RESET;
         r.presets <= PRESETS_RESET;
         r.restart_budget_max <= RESTART_MAX_RESET;
         r.state <= off_state;
         r.start_delay_counter <= START_DELAY_TICKS;
         r.budget <= RESTART_MAX_RESET;
         r.reference_duty <= 8'h00;
         r.output_good_flag <= 1'b0;
         r.alarm_indicator <= 1'b1;
         r.drive <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // ports
   assign ACK_O = r.ack;
   assign DAT_O = r.rdata;
   assign OUTPUT_GOOD_FLAG_O = r.output_good_flag;
   assign ALARM_INDICATOR_O = r.alarm_indicator;
   assign REFERENCE_DUTY_O = r.reference_duty;
   assign DRIVE_ENABLE_O = r.drive;

   ////////////////////////////////////////////////////////////////////////////
   // checks on the machine
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);

   sequence tick_release_s;
      TICK_I && release_hit;
   endsequence

   sequence tick_short_empty_s;
      TICK_I && !release_hit && short_hit && (r.budget == '0)
         && (r.state == active_state || r.state == error_state);
   endsequence

   sequence tick_ramp_up_s;
      TICK_I && !release_hit && (r.state == ramp_state) && (r.reference_duty < target);
   endsequence

   sequence tick_short_spare_s;
      TICK_I && !release_hit && short_hit && (r.budget != '0)
         && (r.state == active_state || r.state == error_state);
   endsequence

   reset_to_off_a: assert property (disable iff (1'b0) RST_I |=> r.state == off_state)
      else $error("state not off after reset");

   off_outputs_a: assert property ((r.state == off_state) |-> (!OUTPUT_GOOD_FLAG_O && ALARM_INDICATOR_O
      && !DRIVE_ENABLE_O && REFERENCE_DUTY_O == 8'h00 && r.start_delay_counter == START_DELAY_TICKS))
      else $error("off state outputs wrong");

   release_override_a: assert property (tick_release_s |=> r.state == off_state)
      else $error("release did not force off");

   short_fault_a: assert property (tick_short_empty_s |=> r.state == fault_state ##1
      (r.state == fault_state || $past(TICK_I)))
      else $error("short with empty budget did not latch fault");

   ramp_step_a: assert property (tick_ramp_up_s |=> REFERENCE_DUTY_O == $past(REFERENCE_DUTY_O) + 8'h01)
      else $error("ramp step not one count");

   good_states_a: assert property ((r.state == active_state || r.state == error_state) |->
      OUTPUT_GOOD_FLAG_O && DRIVE_ENABLE_O)
      else $error("good flag missing in active states");

   fault_sticky_a: assert property ((r.state == fault_state && !release_hit) |=> r.state == fault_state)
      else $error("fault left without release");

   budget_reload_a: assert property ((TICK_I && r.state == off_state && !r.run_sync) |=>
      r.budget == $past(r.restart_budget_max))
      else $error("budget not reloaded");

   tick_only_a: assert property (!TICK_I |=> $stable(r.state) && $stable(REFERENCE_DUTY_O))
      else $error("machine moved without tick");

   error_hold_a: assert property ((TICK_I && !release_hit && r.state == error_state && !short_hit
      && TEMP_MEAS_I >= temp_clear_threshold) |=> r.state == error_state)
      else $error("error cleared above clear threshold");

   start_enter_a: assert property ((TICK_I && r.state == off_state && start_ok) |=> r.state == delay_state)
      else $error("run with good input did not start delay");

   delay_done_a: assert property ((TICK_I && !release_hit && r.state == delay_state
      && r.start_delay_counter == 7'h01) |=> r.state == ramp_state)
      else $error("delay did not end at zero");

   active_reramp_a: assert property ((TICK_I && !release_hit && !short_hit && r.state == active_state
      && r.reference_duty != target && TEMP_MEAS_I <= temp_set_threshold) |=> r.state == ramp_state)
      else $error("active did not return to ramp");

   short_restart_a: assert property (tick_short_spare_s |=> r.state == off_state
      && r.budget == $past(r.budget) - 4'h1)
      else $error("short with budget left did not restart");

   error_alarm_a: assert property (r.state == error_state |-> ALARM_INDICATOR_O)
      else $error("alarm low in error state");

endmodule

/* verif/power_stage_model.sv */
// behavioural power stage: output voltage sample follows the driven reference duty
`timescale 1ns/100ps

module power_stage_model (
   input wire logic clock_i,
   input wire logic drive_i,
   input wire logic [supervisor_pkg::MEAS_W-1:0] duty_i,
   input wire logic short_i,
   output logic [supervisor_pkg::MEAS_W-1:0] vout_o
);
   import supervisor_pkg::*;

   // output collapses to zero when undriven or shorted, one clock of lag
   always_ff @(posedge clock_i) begin
      vout_o <= (drive_i && !short_i) ? duty_i : '0;
   end
endmodule

/* verif/smps_supervisor_fsm_bench.sv */
// self-checking bench for the buck supply supervisor
`timescale 1ns/100ps

module smps_supervisor_fsm_bench;
   import supervisor_pkg::*;

   typedef struct {string nm; logic [31:0] e; logic [31:0] m; logic [10:0] pe; bit pc;} note_t;
   localparam logic [31:0] FULL = 32'h00FF_0F77;
   localparam logic [31:0] NOBUD = 32'h00FF_0077;
   localparam logic [31:0] ST = 32'h0000_0007;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, run = 1'b0, shrt = 1'b0;
   logic [7:0] adr = 8'h00, vin = 8'h80, cur = 8'h10, temp = 8'h50, vout, duty;
   logic [3:0] sel = 4'h0;
   logic [1:0] psel = 2'h0;
   logic [31:0] dat = 32'h0000_0000, dat_o;
   logic ack, good, alarm, drive;
   int n_fail = 0, check_count = 0;
   int order[4] = '{3, 1, 2, 0};
   note_t q[$];
   note_t nt;

   ////////////////////////////////////////////////////////////////////////////
   // clock, design and far side
   always #10 clk = ~clk;

   smps_supervisor_fsm uut (.CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .TICK_I(tick), .RUN_I(run), .PRESET_SEL_I(psel),
      .VIN_MEAS_I(vin), .VOUT_MEAS_I(vout), .CURRENT_MEAS_I(cur), .TEMP_MEAS_I(temp),
      .OUTPUT_GOOD_FLAG_O(good), .ALARM_INDICATOR_O(alarm), .REFERENCE_DUTY_O(duty), .DRIVE_ENABLE_O(drive));

   power_stage_model stage (.clock_i(clk), .drive_i(drive), .duty_i(duty), .short_i(shrt), .vout_o(vout));

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic mm(string nm, logic [31:0] e, logic [31:0] v);
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, v);
   endtask

   function automatic logic [31:0] st(state_t s, logic g, logic a, logic d, logic [3:0] b, logic [7:0] du);
      return {8'h00, du, 4'h0, b, 1'b0, d, a, g, 1'b0, s};
   endfunction

   // classic wishbone single cycle, held until ack is sampled
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) mm("ack", 32'h1, 32'h0);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m, logic [10:0] pe, bit pc);
      q.push_back('{nm, e, m, pe, pc});
      bus(1'b0, a, 32'h0000_0000, 4'hF);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
      q.push_back('{"write", 32'h0, 32'h0, 11'h0, 1'b0});
      bus(1'b1, a, d, s);
   endtask

   task automatic chk(string nm, state_t s, logic g, logic a, logic d, logic [3:0] b, logic [7:0] du,
         logic [31:0] m);
      rd(nm, STATUS_OFFSET, st(s, g, a, d, b, du), m, {g, a, d, du}, m != ST);
   endtask

   // n tick pulses per call, with a quiet cycle between
   task automatic tk(int n);
      repeat (n) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
   endtask

   // step until settled, watching slew and tick count
   task automatic ramp_to(logic [7:0] t);
      int n;
      int diff;
      logic [7:0] pv;
      n = 0;
      diff = (t > duty) ? t - duty : duty - t;
      // leaving the active state costs one tick before the first step
      if (good === 1'b1) diff = diff + 1;
      do begin
         pv = duty;
         tk(1);
         @(negedge clk); // outputs launched by the tick edge have settled
         n++;
         check_count++;
         if ((duty > pv ? duty - pv : pv - duty) > 1) mm("slew", 32'(pv), 32'(duty));
      end while (good !== 1'b1 && n < 300);
      check_count++;
      if (n != diff) mm("ramp ticks", 32'(diff), 32'(n));
      chk("settled", active_state, 1, cur > LIMITS_RESET[OVERCURRENT_LSB +: 8], 1, 0, t, NOBUD);
   endtask

   task automatic up();
      tk(1);
      chk("delay", delay_state, 0, 1, 0, 0, 0, NOBUD);
      tk(99);
      chk("delay end", delay_state, 0, 1, 0, 0, 0, NOBUD);
      tk(1);
      chk("ramp entry", ramp_state, 0, 0, 0, 0, 0, ST);
      ramp_to(PRESETS_RESET[8*psel +: 8]);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // result watcher: oldest note against each acknowledged read
   always @(posedge clk) begin
      if (ack === 1'b1 && q.size() > 0) begin
         nt = q.pop_front();
         if (nt.m != 0) begin
            check_count++;
            if ((dat_o & nt.m) !== (nt.e & nt.m)) mm(nt.nm, nt.e & nt.m, dat_o & nt.m);
         end
         if (nt.pc) begin
            check_count++;
            if ({good, alarm, drive, duty} !== nt.pe) mm({nt.nm, " pins"}, 32'(nt.pe), 32'({good, alarm, drive, duty}));
         end
      end
   end

   // watchdog
   initial begin
      repeat (40000) @(posedge clk);
      mm("watchdog", 32'h0, 32'h1);
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(32'hf7081d20));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      chk("reset status", off_state, 0, 1, 0, 3, 0, FULL);
      rd("limits", LIMITS_OFFSET, LIMITS_RESET, '1, 11'h0, 1'b0);
      rd("presets", PRESETS_OFFSET, PRESETS_RESET, '1, 11'h0, 1'b0);
      wr(LIMITS_OFFSET, 32'h1111_1130, 4'h1);
      wr(RESTART_OFFSET, 32'h0000_0707, 4'h2);
      wr(STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF);
      wr(8'h10, 32'hFFFF_FFFF, 4'hF);
      rd("limits lane", LIMITS_OFFSET, {LIMITS_RESET[31:8], 8'h30}, '1, 11'h0, 1'b0);
      rd("restart", RESTART_OFFSET, 32'(RESTART_MAX_RESET), 32'h0000_000F, 11'h0, 1'b0);
      rd("unmapped", 8'h10, 32'h0, '1, 11'h0, 1'b0);
      chk("status ro", off_state, 0, 1, 0, 3, 0, FULL);
      wr(LIMITS_OFFSET, LIMITS_RESET, 4'hF);
      $display("test registers done");
      cur <= 8'($urandom_range(223));
      temp <= 8'($urandom_range(159));
      vin <= 8'($urandom_range(255, 66));
      run <= 1'b1;
      settle();
      repeat (10) @(posedge clk);
      chk("no tick", off_state, 0, 1, 0, 3, 0, FULL);
      up();
      $display("test startup done");
      for (int i = 0; i < 4; i++) begin
         psel <= 2'(order[i]);
         settle();
         ramp_to(PRESETS_RESET[8*order[i] +: 8]);
      end
      $display("test presets done");
      cur <= 8'hF0;
      tk(1);
      chk("overcurrent", active_state, 1, 1, 1, 3, 8'h60, FULL);
      cur <= 8'h10;
      tk(1);
      chk("current ok", active_state, 1, 0, 1, 3, 8'h60, FULL);
      temp <= 8'hC1;
      tk(1);
      chk("hot", error_state, 1, 1, 1, 3, 8'h60, FULL);
      temp <= 8'hA0;
      tk(1);
      chk("still hot", error_state, 1, 1, 1, 3, 8'h60, FULL);
      temp <= 8'h9F;
      tk(1);
      chk("cooled", active_state, 1, 0, 1, 3, 8'h60, FULL);
      $display("test alarms done");
      vin <= 8'h40;
      tk(1);
      chk("at lockout", active_state, 1, 0, 1, 3, 8'h60, FULL);
      vin <= 8'h3F;
      tk(1);
      chk("lockout", off_state, 0, 1, 0, 3, 0, FULL);
      vin <= 8'h80;
      up();
      $display("test lockout done");
      for (int k = 2; k >= 0; k--) begin
         shrt <= 1'b1;
         if (k == 0) temp <= 8'hC8;
         tk(1);
         shrt <= 1'b0;
         temp <= 8'h50;
         chk("restart", off_state, 0, 1, 0, 4'(k), 0, FULL);
         up();
      end
      shrt <= 1'b1;
      tk(1);
      shrt <= 1'b0;
      chk("fault", fault_state, 0, 1, 0, 0, 0, FULL);
      tk(3);
      chk("sticky", fault_state, 0, 1, 0, 0, 0, FULL);
      run <= 1'b0;
      settle();
      tk(2);
      chk("released", off_state, 0, 1, 0, 3, 0, FULL);
      $display("test shorts done");
      run <= 1'b1;
      settle();
      up();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk("second reset", off_state, 0, 1, 0, 3, 0, FULL);
      $display("test reset done");
      repeat (2) @(posedge clk);
      wrap_up();
   end
endmodule
